//--- src/mtf_pkg.sv
// Shared constants, types and helpers of the transmit timing and flow control block.
package mtf_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] ADDR_LOW_WM = 8'hb0;
	localparam logic [7:0] ADDR_HIGH_WM = 8'hb2;
	localparam logic [7:0] ADDR_OVR_WM = 8'hb4;
	localparam logic [7:0] ADDR_CTRL = 8'hb8;
	localparam logic [7:0] ADDR_STAT = 8'hba;

	// Watermarks hold free receive queue space in bytes.
	localparam logic [15:0] LOW_WM_RESET = 16'h1400;
	localparam logic [15:0] HIGH_WM_RESET = 16'h0c00;
	localparam logic [15:0] OVR_WM_RESET = 16'h0100;
	localparam logic [15:0] CTRL_RESET = 16'h0003;

	localparam int CTRL_FDX_BIT = 0;
	localparam int CTRL_FAST_BIT = 1;
	localparam int CTRL_BP_BIT = 2;

	localparam int STAT_PAUSED_BIT = 0;
	localparam int STAT_XOFF_BIT = 1;
	localparam int STAT_CARRIER_BIT = 2;
	localparam int STAT_RXDROP_BIT = 3;
	localparam int STAT_ATT_LSB = 8;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned CLK_PERIOD_PS = CLK_PERIOD_NS * 1000;
	localparam int unsigned BIT_PS_SLOW = 100000;
	localparam int unsigned BIT_PS_FAST = 10000;
	localparam int unsigned IPG_BITS = 96;
	localparam int unsigned SLOT_BITS = 512;
	localparam int unsigned QUANTUM_BITS = 512;
	localparam int unsigned BP_SILENT_BITS = 48;
	localparam int unsigned BP_HOLD_NS = 400000;
	localparam logic [11:0] BP_HOLD_CYC = 12'(BP_HOLD_NS / CLK_PERIOD_NS);

	localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
	localparam logic [4:0] BACKOFF_LIMIT = 5'h0a;
	localparam logic [15:0] PAUSE_XOFF = 16'hffff;
	localparam logic [15:0] PAUSE_XON = 16'h0000;
	localparam logic [15:0] LFSR_SEED = 16'hace1;

	typedef enum {
		ST_IDLE,
		ST_SEND,
		ST_BACKOFF,
		ST_CARRIER,
		ST_SILENT
	} mtf_state_type;

	// Bit times to clock cycles; least times round up, longest round down.
	function automatic logic [9:0] bits_to_cyc(input int unsigned bits,
		input logic fast, input logic up);
		int unsigned ps;
		int unsigned cyc;
		ps = bits * (fast ? BIT_PS_FAST : BIT_PS_SLOW);
		cyc = up ? (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS
			: ps / CLK_PERIOD_PS;
		if (cyc == 0) begin
			cyc = 1;
		end
		return 10'(cyc);
	endfunction : bits_to_cyc

endpackage : mtf_pkg

//--- src/mtf_sync3.sv
// Three-stage synchroniser whose output follows once stages two and three agree.
`timescale 1ns/1ps
module mtf_sync3 (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Signal
	input wire logic d,
	output logic q
);
	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= 1'b0;
		end else if (s2 == s3) begin
			q <= s3;
		end
	end
endmodule : mtf_sync3

//--- src/mtf_lfsr.sv
// Free-running pseudo-random source for back-off slot selection.
`timescale 1ns/1ps
module mtf_lfsr
	import mtf_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Random value
	output logic [9:0] rnd
);
	logic [15:0] sr;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sr <= LFSR_SEED;
		end else begin
			sr <= {sr[14:0], sr[15] ^ sr[13] ^ sr[12] ^ sr[10]};
		end
	end

	assign rnd = sr[9:0];
endmodule : mtf_lfsr

//--- src/mtf_mac_tx.sv
// Transmit scheduling, pause handling and receive flow control of the MAC.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module mtf_mac_tx
	import mtf_pkg::*;
(
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// Register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [15:0] REG_RDATA,
	// PHY carrier and collision
	input wire logic PHY_CRS,
	input wire logic PHY_COL,
	// Receive side
	input wire logic [15:0] RECEIVE_QUEUE_FREE,
	input wire logic PAUSE_RX_VALID,
	input wire logic [15:0] PAUSE_RX_TIME,
	output logic RX_DROP,
	output logic PAUSED,
	// Frame engine
	input wire logic TX_PENDING,
	input wire logic TX_DONE,
	output logic TX_EN,
	output logic TX_CONTROL,
	output logic [15:0] TX_PAUSE_TIME,
	output logic TX_PREAMBLE,
	output logic TX_ABORT,
	output logic TX_SENT,
	output logic TX_DROPPED
);

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [15:0] flow_low_watermark;
	logic [15:0] flow_high_watermark;
	logic [15:0] flow_overrun_watermark;
	logic [15:0] ctrl;
	logic [15:0] stat;

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			flow_low_watermark <= LOW_WM_RESET;
			flow_high_watermark <= HIGH_WM_RESET;
			flow_overrun_watermark <= OVR_WM_RESET;
			ctrl <= CTRL_RESET;
		end else if (REG_WR) begin
			case (REG_ADDR)
				ADDR_LOW_WM: flow_low_watermark <= REG_WDATA;
				ADDR_HIGH_WM: flow_high_watermark <= REG_WDATA;
				ADDR_OVR_WM: flow_overrun_watermark <= REG_WDATA;
				ADDR_CTRL: ctrl <= REG_WDATA;
				default: ;
			endcase
		end
	end

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			REG_RDATA <= 16'h0000;
		end else if (REG_RD) begin
			case (REG_ADDR)
				ADDR_LOW_WM: REG_RDATA <= flow_low_watermark;
				ADDR_HIGH_WM: REG_RDATA <= flow_high_watermark;
				ADDR_OVR_WM: REG_RDATA <= flow_overrun_watermark;
				ADDR_CTRL: REG_RDATA <= ctrl;
				ADDR_STAT: REG_RDATA <= stat;
				default: REG_RDATA <= 16'h0000;
			endcase
		end else begin
			REG_RDATA <= 16'h0000;
		end
	end

	logic fdx;
	logic fast;
	logic bp_en;

	assign fdx = ctrl[CTRL_FDX_BIT];
	assign fast = ctrl[CTRL_FAST_BIT];
	assign bp_en = ctrl[CTRL_BP_BIT];

	// ****************************************************************
	// Link timing and pin synchronisers
	// ****************************************************************
	logic [9:0] ipg_cyc;
	logic [9:0] slot_cyc;
	logic [9:0] quantum_cyc;
	logic [9:0] silent_cyc;

	assign ipg_cyc = bits_to_cyc(IPG_BITS, fast, 1'b1);
	assign slot_cyc = bits_to_cyc(SLOT_BITS, fast, 1'b1);
	assign quantum_cyc = bits_to_cyc(QUANTUM_BITS, fast, 1'b1);
	assign silent_cyc = bits_to_cyc(BP_SILENT_BITS, fast, 1'b0);

	logic crs;
	logic col;
	logic [9:0] rnd;

	mtf_sync3 u_sync_crs (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.d(PHY_CRS),
		.q(crs)
	);

	mtf_sync3 u_sync_col (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.d(PHY_COL),
		.q(col)
	);

	mtf_lfsr u_lfsr (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.rnd(rnd)
	);

	// Slot mask for the n-th retry, capped at ten bits.
	function automatic logic [9:0] backoff_mask(input logic [4:0] n);
		logic [4:0] k;
		k = (n > BACKOFF_LIMIT) ? BACKOFF_LIMIT : n;
		return 10'((11'h001 << k) - 11'h001);
	endfunction : backoff_mask

	// ****************************************************************
	// Receive queue watermarks
	// ****************************************************************
	logic xoff;
	logic xoff_prev;
	logic fc_pend;
	logic bp_need;

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			xoff <= 1'b0;
		end else if (RECEIVE_QUEUE_FREE <= flow_high_watermark) begin
			xoff <= 1'b1;
		end else if (RECEIVE_QUEUE_FREE >= flow_low_watermark) begin
			xoff <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			RX_DROP <= 1'b0;
		end else begin
			RX_DROP <= RECEIVE_QUEUE_FREE <= flow_overrun_watermark;
		end
	end

	// Half duplex uses the same hysteresis flag to drive carrier.
	assign bp_need = !fdx && bp_en && xoff;

	// ****************************************************************
	// Received pause timer
	// ****************************************************************
	logic [15:0] pause_timer;
	logic [9:0] quantum_cnt;

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			pause_timer <= 16'h0000;
			quantum_cnt <= 10'h000;
		end else if (PAUSE_RX_VALID) begin
			pause_timer <= PAUSE_RX_TIME;
			quantum_cnt <= quantum_cyc;
		end else if (pause_timer != 16'h0000) begin
			if (quantum_cnt <= 10'h001) begin
				pause_timer <= pause_timer - 16'h0001;
				quantum_cnt <= quantum_cyc;
			end else begin
				quantum_cnt <= quantum_cnt - 10'h001;
			end
		end
	end

	assign PAUSED = pause_timer != 16'h0000;

	// ****************************************************************
	// Inter-packet gap
	// ****************************************************************
	logic [9:0] gap_cnt;
	logic gap_ok;

	// The gap restarts while we send or, in half duplex, the medium is busy, so it runs
	// from the frame end or, after collisions, from carrier dropping.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			gap_cnt <= 10'h000;
		end else if (TX_EN || TX_PREAMBLE || (!fdx && crs)) begin
			gap_cnt <= ipg_cyc;
		end else if (gap_cnt != 10'h000) begin
			gap_cnt <= gap_cnt - 10'h001;
		end
	end

	assign gap_ok = (gap_cnt == 10'h000) && (fdx || !crs);

	// ****************************************************************
	// Transmit scheduler
	// ****************************************************************
	mtf_state_type state;
	logic [4:0] attempts;
	logic [9:0] send_cnt;
	logic [9:0] bo_slots;
	logic [9:0] bo_cyc;
	logic [11:0] bp_cnt;
	logic fc_sent;
	logic next_late;
	logic [4:0] next_attempts;

	assign next_late = send_cnt >= slot_cyc;
	assign next_attempts = attempts + 5'h01;

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			state <= ST_IDLE;
			attempts <= 5'h00;
			send_cnt <= 10'h000;
			bo_slots <= 10'h000;
			bo_cyc <= 10'h000;
			bp_cnt <= 12'h000;
			TX_EN <= 1'b0;
			TX_CONTROL <= 1'b0;
			TX_PAUSE_TIME <= 16'h0000;
			TX_PREAMBLE <= 1'b0;
			TX_ABORT <= 1'b0;
			TX_SENT <= 1'b0;
			TX_DROPPED <= 1'b0;
			fc_sent <= 1'b0;
		end else begin
			TX_ABORT <= 1'b0;
			TX_SENT <= 1'b0;
			TX_DROPPED <= 1'b0;
			fc_sent <= 1'b0;
			case (state)
				ST_IDLE: begin
					send_cnt <= 10'h000;
					if (gap_ok && fc_pend) begin
						state <= ST_SEND;
						TX_EN <= 1'b1;
						TX_CONTROL <= 1'b1;
						TX_PAUSE_TIME <= xoff ? PAUSE_XOFF : PAUSE_XON;
					end else if (gap_ok && TX_PENDING && !PAUSED) begin
						state <= ST_SEND;
						TX_EN <= 1'b1;
						TX_CONTROL <= 1'b0;
					end else if (bp_need && !TX_PENDING && !fc_pend) begin
						state <= ST_CARRIER;
						TX_PREAMBLE <= 1'b1;
						bp_cnt <= BP_HOLD_CYC;
					end
				end
				ST_SEND: begin
					if (send_cnt != 10'h3ff) begin
						send_cnt <= send_cnt + 10'h001;
					end
					if (!fdx && col) begin
						TX_EN <= 1'b0;
						TX_ABORT <= 1'b1;
						if (next_late || next_attempts == MAX_ATTEMPTS) begin
							state <= ST_IDLE;
							attempts <= 5'h00;
							TX_DROPPED <= 1'b1;
							fc_sent <= TX_CONTROL;
						end else if (bp_need) begin
							state <= ST_CARRIER;
							attempts <= next_attempts;
							TX_PREAMBLE <= 1'b1;
							bp_cnt <= BP_HOLD_CYC;
						end else begin
							state <= ST_BACKOFF;
							attempts <= next_attempts;
							bo_slots <= rnd & backoff_mask(next_attempts);
							bo_cyc <= slot_cyc;
						end
					end else if (TX_DONE) begin
						state <= ST_IDLE;
						TX_EN <= 1'b0;
						TX_SENT <= 1'b1;
						attempts <= 5'h00;
						fc_sent <= TX_CONTROL;
					end
				end
				ST_BACKOFF: begin
					if (bo_slots == 10'h000) begin
						state <= ST_IDLE;
					end else if (bo_cyc <= 10'h001) begin
						bo_slots <= bo_slots - 10'h001;
						bo_cyc <= slot_cyc;
					end else begin
						bo_cyc <= bo_cyc - 10'h001;
					end
				end
				ST_CARRIER: begin
					if (!bp_need || TX_PENDING || fc_pend) begin
						state <= ST_IDLE;
						TX_PREAMBLE <= 1'b0;
					end else if (col) begin
						bp_cnt <= BP_HOLD_CYC;
					end else if (bp_cnt <= 12'h001) begin
						state <= ST_SILENT;
						TX_PREAMBLE <= 1'b0;
						bp_cnt <= {2'b00, silent_cyc};
					end else begin
						bp_cnt <= bp_cnt - 12'h001;
					end
				end
				ST_SILENT: begin
					if (!bp_need) begin
						state <= ST_IDLE;
					end else if (col || bp_cnt <= 12'h001) begin
						state <= ST_CARRIER;
						TX_PREAMBLE <= 1'b1;
						bp_cnt <= BP_HOLD_CYC;
					end else begin
						bp_cnt <= bp_cnt - 12'h001;
					end
				end
				default: begin
					state <= ST_IDLE;
					TX_EN <= 1'b0;
					TX_PREAMBLE <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************************************
	// Flow control frame request
	// ****************************************************************
	// A watermark crossing that coincides with the end of a control
	// frame keeps the request, so the newer pause value still goes out.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			xoff_prev <= 1'b0;
			fc_pend <= 1'b0;
		end else begin
			xoff_prev <= xoff;
			if (fdx && xoff != xoff_prev) begin
				fc_pend <= 1'b1;
			end else if (fc_sent || !fdx) begin
				fc_pend <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Status
	// ****************************************************************
	always_comb begin
		stat = 16'h0000;
		stat[STAT_PAUSED_BIT] = PAUSED;
		stat[STAT_XOFF_BIT] = xoff;
		stat[STAT_CARRIER_BIT] = TX_PREAMBLE;
		stat[STAT_RXDROP_BIT] = RX_DROP;
		stat[STAT_ATT_LSB +: 5] = attempts;
	end

endmodule : mtf_mac_tx

//--- tb/mtf_mac_tx_properties.sv
// Port checks of the transmit timing and flow control block.
`timescale 1ns/1ps
module mtf_mac_tx_properties
	import mtf_pkg::*;
(
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// Register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_WR,
	// Receive side
	input wire logic [15:0] RECEIVE_QUEUE_FREE,
	input wire logic PAUSE_RX_VALID,
	input wire logic [15:0] PAUSE_RX_TIME,
	input wire logic RX_DROP,
	input wire logic PAUSED,
	// Frame engine
	input wire logic TX_DONE,
	input wire logic TX_EN,
	input wire logic TX_CONTROL,
	input wire logic [15:0] TX_PAUSE_TIME,
	input wire logic TX_PREAMBLE,
	input wire logic TX_ABORT,
	input wire logic TX_SENT,
	input wire logic TX_DROPPED
);
	default clocking @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);
	logic [15:0] ovr;
	logic [7:0] idle;
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			ovr <= OVR_WM_RESET;
		end else if (REG_WR && REG_ADDR == ADDR_OVR_WM) begin
			ovr <= REG_WDATA;
		end
	end
	// Saturates, so a frame soon after reset is not taken for a short gap.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			idle <= 8'hff;
		end else if (TX_EN) begin
			idle <= 8'h00;
		end else if (idle != 8'hff) begin
			idle <= idle + 8'h01;
		end
	end
	chk_drop_mark: assert property (
		$past(RST_N) |-> RX_DROP == ($past(RECEIVE_QUEUE_FREE) <= $past(ovr)))
		else $error("drop flag disagrees with overrun mark");
	chk_pause_load: assert property (
		PAUSE_RX_VALID && PAUSE_RX_TIME != 16'h0000 |=> PAUSED)
		else $error("pause frame did not pause");
	chk_pause_zero: assert property (
		PAUSE_RX_VALID && PAUSE_RX_TIME == 16'h0000 |=> !PAUSED)
		else $error("zero pause did not reload timer");
	chk_paused_ctrl: assert property (
		$rose(TX_EN) && $past(PAUSED) |-> TX_CONTROL)
		else $error("normal frame started while paused");
	chk_frame_gap: assert property (
		$rose(TX_EN) |-> idle >= 8'h09)
		else $error("frame started inside the gap");
	chk_sent_done: assert property (
		TX_EN && TX_DONE && !TX_ABORT |=> TX_SENT && !TX_EN)
		else $error("finished frame not reported");
	chk_ctrl_value: assert property (
		$rose(TX_EN) && TX_CONTROL |->
		TX_PAUSE_TIME == 16'hffff || TX_PAUSE_TIME == 16'h0000)
		else $error("control frame pause value wrong");
	chk_preamble_yield: assert property (
		TX_EN |-> !TX_PREAMBLE)
		else $error("carrier held during a frame");
	cover property (TX_DROPPED);
	cover property (TX_EN && TX_CONTROL && PAUSED);
	cover property ($fell(TX_PREAMBLE) ##[1:8] $rose(TX_PREAMBLE));
endmodule : mtf_mac_tx_properties

bind mtf_mac_tx mtf_mac_tx_properties mtf_mac_tx_properties_inst (
	.CLK_SYS, .RST_N, .REG_ADDR, .REG_WDATA, .REG_WR,
	.RECEIVE_QUEUE_FREE, .PAUSE_RX_VALID, .PAUSE_RX_TIME, .RX_DROP,
	.PAUSED, .TX_DONE, .TX_EN, .TX_CONTROL, .TX_PAUSE_TIME,
	.TX_PREAMBLE, .TX_ABORT, .TX_SENT, .TX_DROPPED);

//--- tb/mtf_station.sv
// Remote station seen through the PHY: carrier, collisions, pause frames.
`timescale 1ns/1ps
module mtf_station (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Device activity
	input wire logic tx_en,
	input wire logic tx_preamble,
	// Bench control
	input wire logic [9:0] col_at,
	input wire logic pause_req,
	input wire logic [15:0] pause_val,
	// Line side
	output logic crs,
	output logic col,
	output logic pause_valid,
	output logic [15:0] pause_time
);
	logic [9:0] age;
	logic [2:0] jam;
	// The jam lasts four cycles so the synchroniser can catch it.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			age <= 10'h000;
			jam <= 3'h0;
		end else begin
			age <= tx_en ? age + 10'h001 : 10'h000;
			if (tx_en && col_at != 10'h000 && age == col_at) begin
				jam <= 3'h4;
			end else if (jam != 3'h0) begin
				jam <= jam - 3'h1;
			end
		end
	end
	assign col = jam != 3'h0;
	// Outside a pause pulse the value toggles, so stale data is never valid.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			crs <= 1'b0;
			pause_valid <= 1'b0;
			pause_time <= 16'h0000;
		end else begin
			crs <= tx_en | tx_preamble | col;
			pause_valid <= pause_req;
			pause_time <= pause_req ? pause_val : ~pause_time;
		end
	end
endmodule : mtf_station

//--- tb/mtf_mac_tx_bench.sv
// Self-checking bench of the transmit timing and flow control block.
`timescale 1ns/1ps
module mtf_mac_tx_bench
	import mtf_pkg::*;
;
	logic clk_sys, rst_n, reg_wr, reg_rd, tx_pending, tx_done, pause_req;
	logic crs, col, pause_valid, rx_drop, paused, tx_en, tx_control;
	logic tx_preamble, tx_abort, tx_sent, tx_dropped;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, free, pause_val, pause_time;
	logic [15:0] tx_pause_time, v, ovr;
	logic [9:0] col_at;
	logic [31:0] lfsr;
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;
	int n, k;

	mtf_mac_tx mtf_mac_tx_inst (
		.CLK_SYS(clk_sys), .RST_N(rst_n), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_RDATA(reg_rdata), .PHY_CRS(crs), .PHY_COL(col),
		.RECEIVE_QUEUE_FREE(free), .PAUSE_RX_VALID(pause_valid),
		.PAUSE_RX_TIME(pause_time), .RX_DROP(rx_drop), .PAUSED(paused),
		.TX_PENDING(tx_pending), .TX_DONE(tx_done), .TX_EN(tx_en),
		.TX_CONTROL(tx_control), .TX_PAUSE_TIME(tx_pause_time),
		.TX_PREAMBLE(tx_preamble), .TX_ABORT(tx_abort),
		.TX_SENT(tx_sent), .TX_DROPPED(tx_dropped));
	mtf_station mtf_station_inst (
		.clk(clk_sys), .rst_n(rst_n), .tx_en(tx_en),
		.tx_preamble(tx_preamble), .col_at(col_at), .pause_req(pause_req),
		.pause_val(pause_val), .crs(crs), .col(col),
		.pause_valid(pause_valid), .pause_time(pause_time));

	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : next_rand

	function automatic logic exp_drop(input logic [15:0] f, m);
		return f <= m;
	endfunction : exp_drop

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		d = reg_rdata;
	endtask : rd

	// Leaves n at the number of cycles waited.
	task automatic till(ref logic s, input logic lvl, input int lim);
		for (n = 0; n < lim && s !== lvl; n++) begin
			@(negedge clk_sys);
		end
	endtask : till

	task automatic done_frame();
		repeat (3) @(posedge clk_sys);
		tx_done <= 1'b1;
		@(posedge clk_sys);
		tx_done <= 1'b0;
		tx_pending <= 1'b0;
		@(negedge clk_sys);
		check(tx_sent, 1'b1);
	endtask : done_frame

	task automatic pause(input logic [15:0] t);
		@(posedge clk_sys);
		pause_val <= t;
		pause_req <= 1'b1;
		@(posedge clk_sys);
		pause_req <= 1'b0;
		// The station registers the request, so the timer loads one edge
		// later; a frame requested earlier would slip past the pause.
		@(posedge clk_sys);
	endtask : pause

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			wrap_up();
		end
	end

	initial begin
		rst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		tx_pending = 1'b0;
		tx_done = 1'b0;
		pause_req = 1'b0;
		pause_val = 16'h0000;
		free = 16'hffff;
		col_at = 10'h000;
		lfsr = 32'h0001784c;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(ADDR_LOW_WM, v);
		check(v, 16'h1400);
		rd(ADDR_HIGH_WM, v);
		check(v, 16'h0c00);
		rd(ADDR_OVR_WM, v);
		check(v, 16'h0100);
		rd(8'hc0, v);
		check(v, 16'h0000);
		rd(ADDR_CTRL, v);
		check(v, CTRL_RESET);
		lfsr = next_rand(lfsr);
		ovr = lfsr[15:0];
		wr(ADDR_OVR_WM, ovr);
		rd(ADDR_OVR_WM, v);
		check(v, ovr);
		// Half duplex without backpressure keeps flow frames out of the way.
		wr(ADDR_CTRL, 16'h0002);
		for (k = 0; k < 8; k++) begin
			lfsr = next_rand(lfsr);
			v = k < 3 ? ovr + 16'(k) - 16'h0001 : lfsr[15:0];
			@(posedge clk_sys);
			free <= v;
			repeat (2) @(negedge clk_sys);
			check(rx_drop, exp_drop(v, ovr));
		end
		@(posedge clk_sys);
		free <= 16'hffff;
		wr(ADDR_CTRL, 16'h0003);
		@(posedge clk_sys);
		free <= HIGH_WM_RESET;
		till(tx_en, 1'b1, 50);
		check(tx_control, 1'b1);
		check(tx_pause_time, 16'hffff);
		done_frame();
		@(posedge clk_sys);
		free <= LOW_WM_RESET - 16'h0001;
		repeat (30) @(negedge clk_sys);
		check(tx_en, 1'b0);
		@(posedge clk_sys);
		free <= LOW_WM_RESET;
		till(tx_en, 1'b1, 50);
		check(tx_control, 1'b1);
		check(tx_pause_time, 16'h0000);
		done_frame();
		pause(16'hffff);
		tx_pending <= 1'b1;
		repeat (100) @(negedge clk_sys);
		check(tx_en, 1'b0);
		check(paused, 1'b1);
		rd(ADDR_STAT, v);
		check(v & 16'h0003, 16'h0001);
		@(posedge clk_sys);
		free <= HIGH_WM_RESET;
		till(tx_en, 1'b1, 50);
		check(tx_control, 1'b1);
		done_frame();
		pause(16'h0000);
		repeat (2) @(negedge clk_sys);
		check(paused, 1'b0);
		pause(16'h0002);
		@(posedge clk_sys);
		tx_pending <= 1'b1;
		till(tx_en, 1'b1, 200);
		check(n >= 103 && n <= 120, 1'b1);
		check(tx_control, 1'b0);
		done_frame();
		@(posedge clk_sys);
		free <= 16'hffff;
		till(tx_en, 1'b1, 50);
		done_frame();
		wr(ADDR_CTRL, 16'h0002);
		@(posedge clk_sys);
		col_at <= 10'h03c;
		tx_pending <= 1'b1;
		till(tx_dropped, 1'b1, 200);
		check(tx_dropped, 1'b1);
		@(posedge clk_sys);
		col_at <= 10'h005;
		till(tx_abort, 1'b1, 200);
		@(posedge clk_sys);
		col_at <= 10'h000;
		till(tx_en, 1'b1, 200);
		check(n >= 10 && n <= 90, 1'b1);
		done_frame();
		wr(ADDR_CTRL, 16'h0006);
		@(posedge clk_sys);
		free <= HIGH_WM_RESET;
		till(tx_preamble, 1'b1, 20);
		check(tx_preamble, 1'b1);
		till(tx_preamble, 1'b0, 4100);
		till(tx_preamble, 1'b1, 60);
		check(n >= 1 && n <= 8, 1'b1);
		@(posedge clk_sys);
		tx_pending <= 1'b1;
		till(tx_en, 1'b1, 60);
		check(tx_en, 1'b1);
		done_frame();
		till(tx_preamble, 1'b1, 60);
		check(tx_preamble, 1'b1);
		// Without the skipped back-off, sixteen tries would overrun the bound.
		@(posedge clk_sys);
		col_at <= 10'h005;
		tx_pending <= 1'b1;
		k = 0;
		for (n = 0; n < 4000 && tx_dropped !== 1'b1; n++) begin
			@(negedge clk_sys);
			if (tx_abort === 1'b1) k++;
		end
		check(16'(k), 16'h0010);
		@(posedge clk_sys);
		col_at <= 10'h000;
		tx_pending <= 1'b0;
		till(tx_preamble, 1'b1, 10);
		check(tx_preamble, 1'b1);
		@(posedge clk_sys);
		free <= 16'hffff;
		till(tx_preamble, 1'b0, 20);
		check(tx_preamble, 1'b0);
		wrap_up();
	end
endmodule : mtf_mac_tx_bench
